// >>> ilod_addr_calc.v
// Data address former for byte and bit oriented operands.
`timescale 1ns/100ps
`include "ilod_map.vh"

module ilod_addr_calc #(
	parameter AW = 12
) (
	input  wire          ext_en,
	input  wire          access_sel,
	input  wire [7:0]    file_field,
	input  wire [3:0]    bank_select_register,
	input  wire [AW-1:0] frame_pointer,
	output reg  [AW-1:0] eff_addr,
	output reg           indexed
);

	always @* begin
		indexed  = 1'b0;
		eff_addr = {AW{1'b0}};
		if (access_sel) begin
			eff_addr = {bank_select_register, file_field}; // RQ5
		end else if (ext_en && (file_field <= `ILOD_IDX_LIMIT)) begin
			// A zero frame pointer yields the plain access bank address.
			indexed  = 1'b1; // RQ6
			eff_addr = frame_pointer + {{(AW-8){1'b0}}, file_field}; // RQ6 RQ8
		end else if (file_field < `ILOD_ACC_SPLIT) begin
			eff_addr = {`ILOD_LOW_BANK, file_field}; // RQ5
		end else begin
			eff_addr = {`ILOD_ACC_HIGH_BANK, file_field}; // RQ5
		end
	end

endmodule // ilod_addr_calc

// >>> ilod_chk.sv
// Concurrent checks on the indexed literal offset decoder ports.
`timescale 1ns/100ps
module ilod_chk #(
	parameter AW = 12
) (
	input wire          clock,
	input wire          rst_n,
	input wire [15:0]   instr_word,
	input wire          instr_ready,
	input wire [AW-1:0] return_stack_top,
	input wire          pc_load,
	input wire [AW-1:0] pc_value,
	input wire          data_addr_valid,
	input wire [AW-1:0] data_addr,
	input wire          data_dest_file,
	input wire          data_indexed,
	input wire          flags_hold,
	input wire          ext_op_ignored,
	input wire [AW-1:0] frame_pointer
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);
	AST_RET_PC: assert property (pc_load |-> pc_value == $past(return_stack_top))
		else $error("pc value wrong");
	AST_RET_FP: assert property (pc_load |-> flags_hold
		&& frame_pointer == $past(frame_pointer) - $past(instr_word[5:0]))
		else $error("frame pointer not reduced");
	AST_NOP: assert property (pc_load |=> !pc_load && instr_ready)
		else $error("second cycle not idle");
	AST_STALL: assert property (!instr_ready |-> pc_load)
		else $error("stall without return");
	AST_DEST: assert property (data_addr_valid |-> data_dest_file == $past(instr_word[9]))
		else $error("destination wrong");
	AST_LIT: assert property (data_addr_valid && !data_indexed && !$past(instr_word[8])
		|-> data_addr == {($past(instr_word[7:0]) < 8'h60) ? 4'h0 : 4'hF, $past(instr_word[7:0])})
		else $error("access bank address wrong");
	AST_IDX: assert property (data_addr_valid && data_indexed |-> !$past(instr_word[8])
		&& $past(instr_word[7:0]) <= 8'h5F
		&& data_addr == $past(frame_pointer) + $past(instr_word[7:0]))
		else $error("indexed address wrong");
	AST_IGN: assert property (ext_op_ignored |-> $past(instr_word[15:8]) == 8'hE9
		&& !flags_hold && frame_pointer == $past(frame_pointer))
		else $error("disabled extended op acted");
endmodule // ilod_chk

bind ilod_decoder ilod_chk #(.AW(AW)) u_chk (.clock(clock), .rst_n(rst_n),
	.instr_word(instr_word), .instr_ready(instr_ready), .return_stack_top(return_stack_top),
	.pc_load(pc_load), .pc_value(pc_value), .data_addr_valid(data_addr_valid),
	.data_addr(data_addr), .data_dest_file(data_dest_file), .data_indexed(data_indexed),
	.flags_hold(flags_hold), .ext_op_ignored(ext_op_ignored), .frame_pointer(frame_pointer));

// >>> ilod_decoder.v
// Extended operand decoder: pointer subtract, subtract-and-return and indexed addressing.
//
// Overview of operation
// RQ1 - Subtract-return: frame pointer minus literal, PC from stack.
// RQ2 - One word, two cycles, NOP second, flags kept.
// RQ3 - Pointer subtract by field; field 11 means return.
// RQ4 - Extended enable also turns on indexed addressing.
// RQ5 - Disabled: access bit picks access bank or bank.
// RQ6 - Enabled, access 0, operand up to 5Fh offsets.
// RQ7 - Remap applies to all byte and bit operations.
// RQ8 - Frame pointer zero gives original access addresses.
// RQ9 - Indexed operand read and written at same address.
//
// Decided for this implementation: register access over APB and the register addresses.
`timescale 1ns/100ps
`include "ilod_map.vh"

module ilod_decoder #(
	parameter AW = 12,
	parameter NP = 3
) (
	input  wire          clock,
	input  wire          rst_n,
	input  wire          psel,
	input  wire          penable,
	input  wire          pwrite,
	input  wire [7:0]    paddr,
	input  wire [31:0]   pwdata,
	output reg  [31:0]   prdata,
	output wire          pready,
	output reg           pslverr,
	input  wire          instr_valid,
	input  wire [15:0]   instr_word,
	input  wire          instr_has_access,
	output wire          instr_ready,
	input  wire [AW-1:0] return_stack_top,
	output reg           pc_load,
	output reg  [AW-1:0] pc_value,
	output reg           data_addr_valid,
	output reg  [AW-1:0] data_addr,
	output reg           data_dest_file,
	output reg           data_indexed,
	output reg           flags_hold,
	output reg           ext_op_ignored,
	output wire [AW-1:0] frame_pointer
);

	reg  [AW-1:0] ptr_ff [0:NP-1];
	reg           ext_en_ff;
	reg  [3:0]    bank_ff;
	reg           busy_ff;
	reg           pc_load_ff;
	reg  [AW-1:0] pc_value_ff;
	reg           addr_valid_ff;
	reg  [AW-1:0] data_addr_ff;
	reg           dest_file_ff;
	reg           indexed_ff;
	reg           flags_hold_ff;
	reg           ignored_ff;
	reg           ill_seen_ff;
	reg  [31:0]   prdata_ff;
	reg           pslverr_ff;

	reg  [31:0]   nxt_prdata;
	reg           nxt_pslverr;
	reg           addr_hit;

	wire          apb_setup;
	wire          apb_write;
	wire          take;
	wire          is_sub_opc;
	wire          sub_exec;
	wire          sub_return;
	wire [1:0]    sel_field;
	wire [5:0]    lit_field;
	wire [AW-1:0] calc_addr;
	wire          calc_indexed;

	assign apb_setup   = psel && !penable;
	assign apb_write   = psel && penable && pwrite;
	assign pready      = 1'b1;
	assign instr_ready = !busy_ff; // RQ2

	assign take       = instr_valid && !busy_ff;
	assign is_sub_opc = (instr_word[`ILOD_OPC_MSB:`ILOD_OPC_LSB] == `ILOD_OPC_HI);
	assign sel_field  = instr_word[`ILOD_SEL_MSB:`ILOD_SEL_LSB];
	assign lit_field  = instr_word[`ILOD_LIT_MSB:`ILOD_LIT_LSB];
	// The extended opcodes only exist while the extended set is on.
	assign sub_exec   = take && is_sub_opc && ext_en_ff; // RQ3 RQ4
	assign sub_return = sub_exec && (sel_field == `ILOD_SEL_RETURN); // RQ3

	assign frame_pointer = ptr_ff[`ILOD_FP_INDEX];

	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ext_en_ff <= `ILOD_CTRL_RST;
			bank_ff   <= `ILOD_BANK_RST;
		end else if (apb_write) begin
			if (paddr == `ILOD_OFS_CTRL) begin
				ext_en_ff <= pwdata[`ILOD_CTRL_EXT_BIT];
			end
			if (paddr == `ILOD_OFS_BANK) begin
				bank_ff <= pwdata[3:0];
			end
		end
	end

	// Instruction execution wins over a software write to the same pointer in
	// one cycle, so that a stack adjustment in flight is never lost.
	genvar g;
	generate
		for (g = 0; g < NP; g = g + 1) begin : g_ptr
			wire        sel_me;
			wire        sw_me;
			wire [31:0] idx;
			wire [31:0] ofs;
			assign idx    = g;
			assign ofs    = `ILOD_OFS_PTR0 + (g * `ILOD_PTR_STRIDE);
			assign sel_me = sub_exec && ((sel_field == idx[1:0]) ||
				((g == `ILOD_FP_INDEX) && (sel_field == `ILOD_SEL_RETURN))); // RQ1 RQ3
			assign sw_me  = apb_write && (paddr == ofs[7:0]);
			always @(posedge clock or negedge rst_n) begin
				if (!rst_n) begin
					ptr_ff[g] <= `ILOD_PTR_RST;
				end else if (sel_me) begin
					ptr_ff[g] <= ptr_ff[g] - {{(AW-6){1'b0}}, lit_field}; // RQ1 RQ3
				end else if (sw_me) begin
					ptr_ff[g] <= pwdata[AW-1:0];
				end
			end
		end
	endgenerate

	ilod_addr_calc #(
		.AW(AW)
	) u_addr_calc (
		.ext_en               (ext_en_ff),
		.access_sel           (instr_word[`ILOD_ACC_BIT]),
		.file_field           (instr_word[`ILOD_FILE_MSB:`ILOD_FILE_LSB]),
		.bank_select_register (bank_ff),
		.frame_pointer        (ptr_ff[`ILOD_FP_INDEX]),
		.eff_addr             (calc_addr),
		.indexed              (calc_indexed)
	);

	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			busy_ff     <= 1'b0;
			pc_load_ff  <= 1'b0;
			pc_value_ff <= {AW{1'b0}};
		end else begin
			// The second cycle of subtract-and-return does nothing but stall.
			busy_ff    <= sub_return; // RQ2
			pc_load_ff <= sub_return; // RQ1
			if (sub_return) begin
				pc_value_ff <= return_stack_top; // RQ1
			end
		end
	end

	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			addr_valid_ff <= 1'b0;
			data_addr_ff  <= {AW{1'b0}};
			dest_file_ff  <= 1'b0;
			indexed_ff    <= 1'b0;
			flags_hold_ff <= 1'b0;
			ignored_ff    <= 1'b0;
		end else begin
			addr_valid_ff <= take && instr_has_access; // RQ7
			flags_hold_ff <= sub_exec; // RQ2
			ignored_ff    <= take && is_sub_opc && !ext_en_ff; // RQ4
			if (take && instr_has_access) begin
				data_addr_ff <= calc_addr; // RQ7 RQ9
				dest_file_ff <= instr_word[`ILOD_DEST_BIT]; // RQ9
				indexed_ff   <= calc_indexed; // RQ6
			end
		end
	end

	// Sticky record of extended opcodes seen while the set was off; the new
	// event wins over a clearing write in the same cycle.
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ill_seen_ff <= 1'b0;
		end else if (take && is_sub_opc && !ext_en_ff) begin
			ill_seen_ff <= 1'b1;
		end else if (apb_write && (paddr == `ILOD_OFS_STATUS) &&
			pwdata[`ILOD_STAT_ILL_BIT]) begin
			ill_seen_ff <= 1'b0;
		end
	end

	always @* begin
		nxt_prdata  = 32'h00000000;
		addr_hit    = 1'b1;
		case (paddr)
			`ILOD_OFS_CTRL: begin
				nxt_prdata[`ILOD_CTRL_EXT_BIT] = ext_en_ff;
			end
			`ILOD_OFS_BANK: begin
				nxt_prdata[3:0] = bank_ff;
			end
			`ILOD_OFS_PTR0: begin
				nxt_prdata[AW-1:0] = ptr_ff[0];
			end
			`ILOD_OFS_PTR1: begin
				nxt_prdata[AW-1:0] = ptr_ff[1];
			end
			`ILOD_OFS_PTR2: begin
				nxt_prdata[AW-1:0] = ptr_ff[2];
			end
			`ILOD_OFS_STATUS: begin
				nxt_prdata[`ILOD_STAT_BUSY_BIT] = busy_ff;
				nxt_prdata[`ILOD_STAT_IDX_BIT]  = indexed_ff;
				nxt_prdata[`ILOD_STAT_ILL_BIT]  = ill_seen_ff;
				nxt_prdata[`ILOD_STAT_ADDR_MSB:`ILOD_STAT_ADDR_LSB] = data_addr_ff;
			end
			default: begin
				addr_hit = 1'b0;
			end
		endcase
		nxt_pslverr = !addr_hit;
	end

	// Read data is captured in the setup cycle because the slave never waits.
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			prdata_ff  <= 32'h00000000;
			pslverr_ff <= 1'b0;
		end else if (apb_setup) begin
			prdata_ff  <= pwrite ? 32'h00000000 : nxt_prdata;
			pslverr_ff <= nxt_pslverr;
		end
	end

	always @* begin
		prdata          = prdata_ff;
		pslverr         = pslverr_ff && psel && penable;
		pc_load         = pc_load_ff;
		pc_value        = pc_value_ff;
		data_addr_valid = addr_valid_ff;
		data_addr       = data_addr_ff;
		data_dest_file  = dest_file_ff;
		data_indexed    = indexed_ff;
		flags_hold      = flags_hold_ff;
		ext_op_ignored  = ignored_ff;
	end

endmodule // ilod_decoder

// >>> ilod_map.vh
// Register map, field positions and decode constants of the indexed literal offset decoder.
`ifndef ILOD_MAP_VH
`define ILOD_MAP_VH

`define ILOD_OFS_CTRL       8'h00
`define ILOD_OFS_BANK       8'h04
`define ILOD_OFS_PTR0       8'h08
`define ILOD_OFS_PTR1       8'h0C
`define ILOD_OFS_PTR2       8'h10
`define ILOD_OFS_STATUS     8'h14
`define ILOD_PTR_STRIDE     4

`define ILOD_CTRL_EXT_BIT   0
`define ILOD_STAT_BUSY_BIT  0
`define ILOD_STAT_IDX_BIT   1
`define ILOD_STAT_ILL_BIT   2
`define ILOD_STAT_ADDR_LSB  16
`define ILOD_STAT_ADDR_MSB  27

`define ILOD_PTR_RST        12'h000
`define ILOD_BANK_RST       4'h0
`define ILOD_CTRL_RST       1'b0

`define ILOD_OPC_HI         8'hE9
`define ILOD_OPC_MSB        15
`define ILOD_OPC_LSB        8
`define ILOD_SEL_MSB        7
`define ILOD_SEL_LSB        6
`define ILOD_LIT_MSB        5
`define ILOD_LIT_LSB        0
`define ILOD_SEL_RETURN     2'b11
`define ILOD_FP_INDEX       2
`define ILOD_ACC_BIT        8
`define ILOD_DEST_BIT       9
`define ILOD_FILE_MSB       7
`define ILOD_FILE_LSB       0

`define ILOD_IDX_LIMIT      8'h5F
`define ILOD_ACC_SPLIT      8'h60
`define ILOD_ACC_HIGH_BANK  4'hF
`define ILOD_LOW_BANK       4'h0

`endif

// >>> indexed_literal_offset_decode_bench.sv
// Self-checking bench for the indexed literal offset decoder.
`timescale 1ns/100ps
`include "ilod_map.vh"
module indexed_literal_offset_decode_bench;
	reg         clock = 0;
	reg         rst_n = 0;
	reg         psel = 0, penable = 0, pwrite = 0;
	reg  [7:0]  paddr = 0;
	reg  [31:0] pwdata = 0, r = 32'h52C7;
	reg         instr_valid = 0, instr_has_access = 0;
	reg  [15:0] instr_word = 0;
	reg  [11:0] return_stack_top = 0, ad, la = 0, p [0:2];
	wire [31:0] prdata;
	wire        pready, pslverr, instr_ready, pc_load, data_addr_valid;
	wire        data_dest_file, data_indexed, flags_hold, ext_op_ignored;
	wire [11:0] pc_value, data_addr, frame_pointer;
	reg  [7:0]  f;
	reg  [5:0]  k;
	reg         a, d, ix, ext = 0, li = 0;
	reg  [3:0]  bk;
	reg  [32:0] qa [$], qr [$], qp [$];
	integer     fails = 0, n_compared = 0, i, j;

	ilod_decoder #(.AW(12), .NP(3)) u_dut (.clock, .rst_n, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .instr_valid, .instr_word,
		.instr_has_access, .instr_ready, .return_stack_top, .pc_load, .pc_value,
		.data_addr_valid, .data_addr, .data_dest_file, .data_indexed, .flags_hold,
		.ext_op_ignored, .frame_pointer);

	initial forever #5 clock = ~clock;

	function [31:0] lfsr(input [31:0] s);
		lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task chk(input [32:0] got, input [32:0] exp);
		n_compared = n_compared + 1;
		if (got !== exp) begin
			fails = fails + 1;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task chk_addr(input [13:0] got);
		chk(got, qa.size() ? qa.pop_front() : 33'bx);
	endtask

	task chk_pc(input [11:0] got);
		chk(got, qp.size() ? qp.pop_front() : 33'bx);
	endtask

	task chk_read(input [32:0] got);
		chk(got, qr.size() ? qr.pop_front() : 33'bx);
	endtask

	// A result that never appeared leaves its note behind and fails the run.
	task finish_test;
		if (qa.size() + qr.size() + qp.size() != 0)
			fails = fails + 1;
		if (fails == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// A read notes its expected word; the monitor compares it at the access edge.
	task apb(input [7:0] ad8, input w, input [31:0] wd, input [32:0] e);
		if (!w)
			qr.push_back(e);
		@(posedge clock);
		psel <= 1;
		paddr <= ad8;
		pwrite <= w;
		pwdata <= wd;
		@(posedge clock);
		penable <= 1;
		@(posedge clock);
		while (!pready) @(posedge clock);
		psel <= 0;
		penable <= 0;
	endtask

	task ins(input [15:0] w, input h);
		@(posedge clock);
		instr_valid <= 1;
		instr_word <= w;
		instr_has_access <= h;
		return_stack_top <= r[27:16];
		@(posedge clock);
		while (!instr_ready) @(posedge clock);
		instr_valid <= 0;
	endtask

	always @(posedge clock) begin
		if (data_addr_valid)
			chk_addr({data_indexed, data_dest_file, data_addr});
		if (pc_load)
			chk_pc(pc_value);
		if (psel && penable && !pwrite)
			chk_read({pslverr, prdata});
	end

	initial begin
		#50000;
		fails = fails + 1;
		finish_test;
	end

	initial begin
		p[0] = 0;
		p[1] = 0;
		p[2] = 0;
		repeat (4) @(posedge clock);
		rst_n <= 1;
		for (i = 0; i < 6; i = i + 1)
			apb(i * 4, 0, 0, 0);
		apb(8'h18, 0, 0, 33'h1_0000_0000);
		// Third pass keeps the frame pointer at zero for the compatibility case.
		for (j = 0; j < 3; j = j + 1) begin
			ext = j > 0;
			r = lfsr(r);
			bk = r[3:0];
			p[2] = (j == 2) ? 12'h000 : r[15:4];
			apb(`ILOD_OFS_CTRL, 1, ext, 0);
			apb(`ILOD_OFS_BANK, 1, r, 0);
			apb(`ILOD_OFS_BANK, 0, 0, r[3:0]);
			apb(`ILOD_OFS_PTR2, 1, p[2], 0);
			for (i = 0; i < 40; i = i + 1) begin
				r = lfsr(r);
				f = (i < 4) ? 8'h5E + i : r[7:0];
				a = (i < 4) ? 1'b0 : r[8];
				d = r[9];
				ix = ext && !a && f <= 8'h5F;
				ad = a ? {bk, f} : ix ? p[2] + f : {(f < 8'h60) ? 4'h0 : 4'hF, f};
				la = ad;
				li = ix;
				qa.push_back({ix, d, ad});
				ins({6'h09, d, a, f}, 1);
			end
		end
		for (i = 0; i < 4; i = i + 1) begin
			r = lfsr(r);
			k = (i == 3) ? 6'h3F : r[5:0];
			p[i % 3 + (i == 3) * 2] = p[i % 3 + (i == 3) * 2] - k;
			if (i == 3)
				qp.push_back(r[27:16]);
			ins({8'hE9, i[1:0], k}, 0);
		end
		for (i = 0; i < 3; i = i + 1)
			apb(`ILOD_OFS_PTR0 + i * 4, 0, 0, p[i]);
		apb(`ILOD_OFS_CTRL, 1, 0, 0);
		ins(16'hE9C5, 0);
		apb(`ILOD_OFS_STATUS, 0, 0, {4'h0, la, 13'h0, 1'b1, li, 1'b0});
		apb(`ILOD_OFS_PTR2, 0, 0, p[2]);
		apb(`ILOD_OFS_STATUS, 1, 32'h4, 0);
		apb(`ILOD_OFS_STATUS, 0, 0, {4'h0, la, 13'h0, 1'b0, li, 1'b0});
		// Let the monitor see the last access edge before the run ends.
		repeat (2) @(posedge clock);
		finish_test;
	end
endmodule // indexed_literal_offset_decode_bench
